// ==== rtl/cmd_ring_device.sv ====
// coprocessor end: ring memory, offsets, fetch and display-list writer
`timescale 1ns/100ps
// Overview of operation
// - read offset advances as commands execute
// - host sets write offset at list end
// - offsets are byte offsets, not addresses
// - ring mapped 108000h to 108fffh contiguously
// - equal offsets means ring empty, done
// - fetch commands until read reaches write
// - entries past write offset stay unexecuted
// - host polls until offsets equal
// - host starts list at current write offset
// - commands are whole four-byte words
// - host writes base plus offset per command
// - host advances local offset by length
// - offsets wrap from 4095 back to 0
// - empty ring accepts up to 4092 bytes; host still writes 1024 words (4096 bytes) for a count of 0
// - consumed commands become display-list entries
// - host may write display list directly
// - do not mix both writers per screen
module cmd_ring_device (
  input wire logic i_clk,
  input wire logic i_rst_n,
  cmd_ring_if.device ring,
  input wire logic i_dl_wr_en,
  input wire logic [9:0] i_dl_wr_idx,
  input wire logic [31:0] i_dl_wr_data,
  output logic o_dl_wr_en,
  output logic [9:0] o_dl_wr_idx,
  output logic [31:0] o_dl_wr_data,
  output logic o_busy,
  output logic o_empty
);
  // ----------------------------------------------------------------
  // storage and offsets
  // ----------------------------------------------------------------
  logic [31:0] ring_mem [cmd_ring_pkg::RING_WORDS];  // ring words
  logic [11:0] rd_ofs;  // coprocessor position
  logic [11:0] wr_ofs;  // host-published end of list
  logic [31:0] cur_word;  // word being executed
  logic [9:0] dl_idx;  // next display-list slot
  cmd_ring_pkg::cp_state_type state;
  logic in_ring;  // write address falls in ring window
  logic pending;  // work outstanding
  logic [23:0] ring_rel;  // address relative to base

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // ring window decode
  assign in_ring = (ring.wr_addr >= cmd_ring_pkg::RING_BASE) &&
                   (ring.wr_addr <= cmd_ring_pkg::RING_TOP);
  // strip base, keep only byte offset
  assign ring_rel = ring.wr_addr - cmd_ring_pkg::RING_BASE;
  // any difference is work, wrap-safe equality
  assign pending = (rd_ofs != wr_ofs);

  // ----------------------------------------------------------------
  // ring memory writes
  // ----------------------------------------------------------------
  // no reset on storage: contents are only meaningful once written
  always_ff @(posedge i_clk) begin
    // word-granular store, low two bits ignored
    if (ring.wr_en && in_ring) begin
      ring_mem[ring_rel[cmd_ring_pkg::OFS_W-1:2]] <= ring.wr_data;
    end
  end

  // ----------------------------------------------------------------
  // write offset register
  // ----------------------------------------------------------------
  // host-owned; misaligned bits are dropped so fetch stays on words
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ofs <= cmd_ring_pkg::OFS_RESET;
    end else if (ring.wptr_en) begin
      // only this update releases new entries
      wr_ofs <= ring.wptr_data & ~cmd_ring_pkg::OFS_ALIGN_MASK;
    end
  end

  // ----------------------------------------------------------------
  // coprocessor sequencer
  // ----------------------------------------------------------------
  // one word per two cycles: fetch then execute
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= cmd_ring_pkg::CP_IDLE;
      rd_ofs <= cmd_ring_pkg::OFS_RESET;
      cur_word <= 32'h00000000;
    end else begin
      case (state)
        cmd_ring_pkg::CP_IDLE: begin
          // start when write offset moves ahead
          if (pending) begin
            state <= cmd_ring_pkg::CP_FETCH;
          end
        end
        cmd_ring_pkg::CP_FETCH: begin
          // fetch a whole word at the read offset
          cur_word <= ring_mem[rd_ofs[cmd_ring_pkg::OFS_W-1:2]];
          state <= cmd_ring_pkg::CP_EXEC;
        end
        cmd_ring_pkg::CP_EXEC: begin
          // 12-bit sum wraps 4095 back to 0
          rd_ofs <= rd_ofs + cmd_ring_pkg::WORD_BYTES;
          if ((rd_ofs + cmd_ring_pkg::WORD_BYTES) != wr_ofs) begin
            state <= cmd_ring_pkg::CP_FETCH;
          end else begin
            state <= cmd_ring_pkg::CP_IDLE;
          end
        end
        default: begin
          state <= cmd_ring_pkg::CP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // display-list writer
  // ----------------------------------------------------------------
  // direct host writes pass through when coprocessor is silent;
  // mixing both in one screen corrupts the list, so host must pick one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dl_idx <= cmd_ring_pkg::DL_START_IDX;
      o_dl_wr_en <= 1'b0;
      o_dl_wr_idx <= 10'h000;
      o_dl_wr_data <= 32'h00000000;
    end else if (state == cmd_ring_pkg::CP_EXEC) begin
      // executed command becomes a list entry
      o_dl_wr_en <= 1'b1;
      o_dl_wr_data <= cur_word;
      if (cur_word == cmd_ring_pkg::BEGIN_LIST_WORD) begin
        // list start rewinds to slot 0 and is itself stored there
        o_dl_wr_idx <= cmd_ring_pkg::DL_START_IDX;
        dl_idx <= cmd_ring_pkg::DL_START_IDX + 10'h001;
      end else begin
        o_dl_wr_idx <= dl_idx;
        dl_idx <= dl_idx + 10'h001;
      end
    end else begin
      o_dl_wr_en <= i_dl_wr_en;
      o_dl_wr_idx <= i_dl_wr_idx;
      o_dl_wr_data <= i_dl_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // offsets exported as byte offsets
  assign ring.rd_ofs = rd_ofs;
  assign ring.wr_ofs = wr_ofs;
  assign o_busy = (state != cmd_ring_pkg::CP_IDLE);
  // empty once read offset reaches write offset
  assign o_empty = !pending;
endmodule

// ==== rtl/cmd_ring_pkg.sv ====
// shared constants for the coprocessor command ring
package cmd_ring_pkg;
  // ring placement in device memory space
  localparam logic [23:0] RING_BASE = 24'h108000;
  localparam logic [23:0] RING_TOP = 24'h108fff;
  // ring geometry
  localparam int OFS_W = 12;
  localparam logic [11:0] OFS_RESET = 12'h000;
  localparam logic [11:0] WORD_BYTES = 12'h004;
  localparam int WORD_IDX_W = 10;
  localparam int RING_WORDS = 1024;
  localparam logic [11:0] OFS_ALIGN_MASK = 12'h003;
  // display-list memory geometry
  localparam int DL_IDX_W = 10;
  // command word that opens a new display list
  localparam logic [31:0] BEGIN_LIST_WORD = 32'hffffff00;
  localparam logic [9:0] DL_START_IDX = 10'h000;
  // coprocessor fetch/execute states
  typedef enum logic [1:0] {
    CP_IDLE,
    CP_FETCH,
    CP_EXEC
  } cp_state_type;
  // host list-building states
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_POLL,
    HS_WRITE,
    HS_COMMIT,
    HS_DONE
  } hs_state_type;
endpackage

// ==== rtl/cmd_ring_if.sv ====
// link between host and coprocessor command ring
`timescale 1ns/100ps
interface cmd_ring_if;
  logic wr_en;           // ring word write strobe
  logic [23:0] wr_addr;  // absolute byte address of word
  logic [31:0] wr_data;  // command word
  logic wptr_en;         // write offset update strobe
  logic [11:0] wptr_data;
  logic [11:0] rd_ofs;   // device read offset
  logic [11:0] wr_ofs;   // device write offset
  modport device (
    input wr_en, wr_addr, wr_data, wptr_en, wptr_data,
    output rd_ofs, wr_ofs
  );
  modport host (
    output wr_en, wr_addr, wr_data, wptr_en, wptr_data,
    input rd_ofs, wr_ofs
  );
endinterface

// ==== rtl/cmd_ring_host.sv ====
// host end: polls offsets, writes a command list, publishes write offset
`timescale 1ns/100ps
module cmd_ring_host (
  input wire logic i_clk,
  input wire logic i_rst_n,
  cmd_ring_if.host ring,
  input wire logic i_start,          // begin a new list
  input wire logic [9:0] i_count,    // number of words in list
  input wire logic i_word_valid,     // word from user ready
  input wire logic [31:0] i_word,
  output logic o_word_ready,         // word accepted this cycle
  output logic o_busy,
  output logic o_done                // one-cycle pulse at commit
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cmd_ring_pkg::hs_state_type state;
  logic [11:0] local_ofs;  // next free ring offset
  logic [10:0] left;       // words still to write
  logic wr_en;
  logic [23:0] wr_addr;
  logic [31:0] wr_data;
  logic wptr_en;
  logic [11:0] wptr_data;

  // ----------------------------------------------------------------
  // list builder
  // ----------------------------------------------------------------
  // a count of 0 means 1024 words, the full 4096-byte ring
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= cmd_ring_pkg::HS_IDLE;
      local_ofs <= cmd_ring_pkg::OFS_RESET;
      left <= 11'h000;
      wr_en <= 1'b0;
      wr_addr <= 24'h000000;
      wr_data <= 32'h00000000;
      wptr_en <= 1'b0;
      wptr_data <= cmd_ring_pkg::OFS_RESET;
      o_done <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      wptr_en <= 1'b0;
      o_done <= 1'b0;
      case (state)
        cmd_ring_pkg::HS_IDLE: begin
          if (i_start) begin
            left <= (i_count == 10'h000) ? 11'h400 : {1'b0, i_count};
            state <= cmd_ring_pkg::HS_POLL;
          end
        end
        cmd_ring_pkg::HS_POLL: begin
          // wait for previous list to drain
          if (ring.rd_ofs == ring.wr_ofs) begin
            // new list starts at read-back write offset
            local_ofs <= ring.wr_ofs;
            state <= cmd_ring_pkg::HS_WRITE;
          end
        end
        cmd_ring_pkg::HS_WRITE: begin
          if (i_word_valid) begin
            // absolute address is base plus offset
            wr_en <= 1'b1;
            wr_addr <= cmd_ring_pkg::RING_BASE + {12'h000, local_ofs};
            wr_data <= i_word;
            local_ofs <= local_ofs + cmd_ring_pkg::WORD_BYTES;
            left <= left - 11'h001;
            // up to full ring before publishing
            if (left == 11'h001) begin
              state <= cmd_ring_pkg::HS_COMMIT;
            end
          end
        end
        cmd_ring_pkg::HS_COMMIT: begin
          wptr_en <= 1'b1;
          wptr_data <= local_ofs;
          o_done <= 1'b1;
          state <= cmd_ring_pkg::HS_IDLE;
        end
        default: begin
          state <= cmd_ring_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_word_ready = (state == cmd_ring_pkg::HS_WRITE) && i_word_valid;
  assign o_busy = (state != cmd_ring_pkg::HS_IDLE);
  assign ring.wr_en = wr_en;
  assign ring.wr_addr = wr_addr;
  assign ring.wr_data = wr_data;
  assign ring.wptr_en = wptr_en;
  assign ring.wptr_data = wptr_data;
endmodule

// ==== tb/cmd_ring_properties.sv ====
// concurrent checks on the host to coprocessor ring link
`timescale 1ns/100ps
module cmd_ring_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic wr_en,
  input wire logic [23:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic wptr_en,
  input wire logic [11:0] wptr_data,
  input wire logic [11:0] rd_ofs,
  input wire logic [11:0] wr_ofs
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // link assertions
  // ----------------------------------------
  a_addr_in_window:
    assert property (wr_en |-> wr_addr >= cmd_ring_pkg::RING_BASE &&
      wr_addr <= cmd_ring_pkg::RING_TOP) else $error("ring addr outside");
  a_addr_word_aligned:
    assert property (wr_en |-> wr_addr[1:0] == 2'h0)
      else $error("ring addr unaligned");
  a_wptr_word_aligned:
    assert property (wptr_en |-> wptr_data[1:0] == 2'h0)
      else $error("write offset unaligned");
  a_wr_ofs_follows:
    assert property (wptr_en |=> wr_ofs == $past(wptr_data))
      else $error("write offset not taken");
  a_wr_ofs_held:
    assert property ($changed(wr_ofs) |-> $past(wptr_en))
      else $error("write offset moved alone");
  a_rd_word_step:
    assert property ($changed(rd_ofs) |-> rd_ofs == $past(rd_ofs) + 12'h004)
      else $error("read offset bad step");
  a_rd_idle_empty:
    assert property (rd_ofs == wr_ofs |=> $stable(rd_ofs))
      else $error("read offset moved when empty");
  a_drain_progress:
    assert property (rd_ofs != wr_ofs |-> ##[1:4] $changed(rd_ofs))
      else $error("pending work stalled");
  a_host_waits_drain:
    assert property (wr_en || wptr_en |-> rd_ofs == wr_ofs)
      else $error("host wrote before drain");
  a_host_next_word:
    assert property (wr_en && $past(wr_en) |->
      wr_addr[11:0] == $past(wr_addr[11:0]) + 12'h004)
      else $error("host offset not advanced");
  // main scenarios
  c_commit: cover property (wptr_en);
  c_burst: cover property (wr_en ##1 wr_en);
  c_rd_wrap: cover property ($past(rd_ofs) == 12'hffc && rd_ofs == 12'h000);
endmodule

// ==== tb/testbench.sv ====
// self-checking bench joining host and coprocessor ends
`timescale 1ns/100ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  logic [9:0] i_count = 10'h000;
  logic i_word_valid = 1'b0;
  logic [31:0] i_word = 32'h00000000;
  logic dl_en = 1'b0; // direct display-list write
  logic [9:0] dl_idx = 10'h000;
  logic [31:0] dl_data = 32'h00000000;
  logic o_word_ready, hs_busy, o_done, o_dl_wr_en, dev_busy, o_empty;
  logic [9:0] o_dl_wr_idx;
  logic [31:0] o_dl_wr_data;
  int err_count = 0;
  int samples_checked = 0;
  int dl_count = 0; // display-list writes seen
  logic [9:0] last_idx;
  logic [31:0] last_data;
  cmd_ring_if ring_if ();
  always #20 i_clk = ~i_clk;
  cmd_ring_host cmd_ring_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .ring(ring_if), .i_start(i_start), .i_count(i_count),
    .i_word_valid(i_word_valid), .i_word(i_word),
    .o_word_ready(o_word_ready), .o_busy(hs_busy), .o_done(o_done));
  cmd_ring_device cmd_ring_device_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .ring(ring_if), .i_dl_wr_en(dl_en), .i_dl_wr_idx(dl_idx),
    .i_dl_wr_data(dl_data), .o_dl_wr_en(o_dl_wr_en),
    .o_dl_wr_idx(o_dl_wr_idx), .o_dl_wr_data(o_dl_wr_data),
    .o_busy(dev_busy), .o_empty(o_empty));
  cmd_ring_properties cmd_ring_properties_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .wr_en(ring_if.wr_en), .wr_addr(ring_if.wr_addr),
    .wr_data(ring_if.wr_data), .wptr_en(ring_if.wptr_en),
    .wptr_data(ring_if.wptr_data), .rd_ofs(ring_if.rd_ofs),
    .wr_ofs(ring_if.wr_ofs));
  // display-list monitor, keeps only the last write
  always @(posedge i_clk) begin
    if (o_dl_wr_en === 1'b1) begin
      dl_count++;
      last_idx = o_dl_wr_idx;
      last_data = o_dl_wr_data;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one list: begin word first, then the word index as data
  task automatic send_list(input logic [9:0] n, input int total);
    int i;
    int w;
    @(negedge i_clk);
    i_start = 1'b1;
    i_count = n;
    @(negedge i_clk);
    i_start = 1'b0;
    for (i = 0; i < total; i++) begin
      i_word = (i == 0) ? cmd_ring_pkg::BEGIN_LIST_WORD : 32'(i);
      i_word_valid = 1'b1;
      #1;
      for (w = 0; w < 50 && o_word_ready !== 1'b1; w++) begin
        @(negedge i_clk);
      end
      @(negedge i_clk);
    end
    i_word_valid = 1'b0;
    for (w = 0; w < 50 && o_done !== 1'b1; w++) begin
      @(negedge i_clk);
    end
    @(negedge i_clk);
    for (w = 0; w < 3000 && o_empty !== 1'b1; w++) begin
      @(negedge i_clk);
    end
    // last list write lands one edge after the final execute
    @(negedge i_clk);
    @(negedge i_clk);
  endtask
  // watchdog, far beyond the roughly 3100 cycles the tests need
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    check(ring_if.rd_ofs, 32'h0);
    check({o_empty, dev_busy}, 32'h2);
    send_list(10'h003, 3);
    check(ring_if.wr_ofs, 32'h00c);
    check(ring_if.rd_ofs, 32'h00c);
    check(dl_count, 32'd3);
    check(last_idx, 32'h002);
    check(last_data, 32'h2);
    check(hs_busy, 32'h0);
    // 1023 words from offset 12 wrap past the top of the ring;
    // a full 4096 bytes would leave the offsets equal, i.e. empty
    dl_count = 0;
    send_list(10'h3ff, 1023);
    check(ring_if.wr_ofs, 32'h008);
    check(ring_if.rd_ofs, 32'h008);
    check(dl_count, 32'd1023);
    check(last_idx, 32'h3fe);
    check(last_data, 32'h3fe);
    check(hs_busy, 32'h0);
    // direct write only while the ring is idle
    // direct display-list write while idle, one cycle late
    dl_en = 1'b1;
    dl_idx = 10'h005;
    dl_data = 32'h0000abcd;
    @(negedge i_clk);
    dl_en = 1'b0;
    check({o_dl_wr_en, o_dl_wr_idx}, {1'b1, 10'h005});
    check(o_dl_wr_data, 32'h0000abcd);
    print_verdict();
  end
endmodule
